// ==== src/dctwo_top.sv ====
// ca training, write leveling and termination control of the dram die
//
// How it works
// - training runs entry, first session, remap, exit
// - unused dq drive valid levels, dqs static
// - training output timed from ck falling edge
// - repeated chip selects each count as samples
// - entry and exit decoded from identical edges
// - entry is write 29h with a4h
// - exit is write 2ah with a8h
// - remap is write 30h with c0h
// - first session maps ca rise/fall to dq pairs
// - remap puts ca4, ca9 on dq0/1, dq8/9
// - leveling bit seven enters and leaves leveling
// - strobe rise samples clock onto whole byte
// - termination follows pin unless forced off
// - nonzero two-bit field enables termination resistance
// - power-down enable bit keeps termination in power-down
// - termination resumes from pin after reads
// - write command: cs low, ca3..0 low rising
`timescale 1ns/1ps
`default_nettype none
module dctwo_top
  import dctwo_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic              resetn_in,
  input  wire logic              ck_t_in,
  input  wire logic              cs_n_in,
  input  wire logic              cke_in,
  input  wire logic [CA_W-1:0]   ca_in,
  input  wire logic [NBYTES-1:0] dqs_t_in,
  input  wire logic              termination_pin_in,
  input  wire logic              read_busy_in,
  input  wire logic              self_refresh_in,
  input  wire logic              deep_power_down_in,
  output logic      [DQ_W-1:0]   dq_out,
  output logic                   dq_oe_out,
  output logic                   term_dq_out,
  output logic                   term_dqs_out,
  output logic      [1:0]        termination_resistance_out,
  output logic                   training_active_out,
  output logic                   leveling_active_out
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge detection
  logic [SYNC_W-1:0]     pins_s;
  logic                  ck_s;
  logic                  cs_n_s;
  logic                  cke_s;
  logic                  term_pin_s;
  logic [NBYTES-1:0]     dqs_s;
  logic [CA_W-1:0]       ca_s;
  logic                  ck_d_reg;
  logic [NBYTES-1:0]     dqs_d_reg;
  logic                  ck_rise;
  logic                  ck_fall;
  logic [NBYTES-1:0]     dqs_rise;

  dctwo_sync #(.W(SYNC_W)) u_sync (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .async_in  ({ck_t_in, cs_n_in, cke_in, termination_pin_in,
                 dqs_t_in, ca_in}),
    .sync_out  (pins_s)
  );

  assign {ck_s, cs_n_s, cke_s, term_pin_s, dqs_s, ca_s} = pins_s;
  assign ck_rise  = ck_s & ~ck_d_reg;
  assign ck_fall  = ~ck_s & ck_d_reg;
  assign dqs_rise = dqs_s & ~dqs_d_reg;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ck_d_reg  <= 1'b0;
      dqs_d_reg <= '0;
    end else begin
      ck_d_reg  <= ck_s;
      dqs_d_reg <= dqs_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command capture: rising half on ck rise, falling half on ck fall
  logic                  cs_sel_reg;
  logic [CA_W-1:0]       ca_rise_reg;
  logic                  slot_done;
  logic                  is_mrw;
  dctwo_mrw_type         mode_reg_write_cmd;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cs_sel_reg  <= 1'b0;
      ca_rise_reg <= '0;
    end else if (ck_rise) begin
      cs_sel_reg  <= ~cs_n_s;
      ca_rise_reg <= ca_s;
    end
  end

  // decoding uses the falling half live, so no extra capture flop
  assign slot_done = cs_sel_reg & ck_fall;
  assign is_mrw    = slot_done & (ca_rise_reg[3:0] == MRW_OPCODE);
  // falling ca1..0 carry the address top bits, rising ca9..4 the rest
  assign mode_reg_write_cmd.addr  = {ca_s[1:0], ca_rise_reg[9:4]};
  assign mode_reg_write_cmd.op    = ca_s[9:2];

  ////////////////////////////////////////////////////////////////////////////
  // training state machine
  dctwo_train_state_type state_reg;
  dctwo_train_state_type state_next;
  logic                  hit_entry;
  logic                  hit_exit;
  logic                  hit_remap;
  logic                  in_train;
  logic                  sample_evt;

  // entry and exit have equal halves, so they decode before training
  assign hit_entry = is_mrw & (mode_reg_write_cmd.addr == TRAIN_ENTRY_ADDR)
                     & (mode_reg_write_cmd.op == TRAIN_ENTRY_OP);
  assign hit_exit  = is_mrw & (mode_reg_write_cmd.addr == TRAIN_EXIT_ADDR)
                     & (mode_reg_write_cmd.op == TRAIN_EXIT_OP);
  assign hit_remap = is_mrw & (mode_reg_write_cmd.addr == TRAIN_REMAP_ADDR)
                     & (mode_reg_write_cmd.op == TRAIN_REMAP_OP);
  assign in_train  = (state_reg != TR_IDLE);
  assign sample_evt = slot_done & in_train & ~hit_exit & ~hit_remap
                      & ~hit_entry;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TR_IDLE: begin
        if (hit_entry) begin
          state_next = TR_FIRST;
        end
      end
      TR_FIRST: begin
        if (hit_exit) begin
          state_next = TR_IDLE;
        end else if (hit_remap && cke_s) begin
          state_next = TR_REMAP;
        end
      end
      TR_REMAP: begin
        if (hit_exit) begin
          state_next = TR_IDLE;
        end
      end
      default: begin
        state_next = TR_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg           <= TR_IDLE;
      training_active_out <= 1'b0;
    end else begin
      state_reg           <= state_next;
      training_active_out <= (state_next != TR_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode registers for leveling and termination
  logic [7:0]            level_ctrl_reg;
  logic [7:0]            term_cfg_reg;
  logic                  lvl_on;
  logic                  wr_level;
  logic                  wr_term;

  assign lvl_on   = level_ctrl_reg[LEVEL_EN_BIT];
  assign wr_level = is_mrw & ~in_train & (mode_reg_write_cmd.addr == LEVEL_CTRL_ADDR);
  // while leveling the termination write is ignored; the leveling write is honoured
  assign wr_term  = is_mrw & ~in_train & ~lvl_on
                    & (mode_reg_write_cmd.addr == TERM_CFG_ADDR);

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      level_ctrl_reg <= LEVEL_CTRL_RST;
      term_cfg_reg   <= TERM_CFG_RST;
    end else begin
      if (wr_level) begin
        level_ctrl_reg <= mode_reg_write_cmd.op;
      end
      if (wr_term) begin
        term_cfg_reg <= mode_reg_write_cmd.op;
      end
    end
  end

  assign leveling_active_out = level_ctrl_reg[LEVEL_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // data lane mapping for training and leveling
  logic [DQ_W-1:0]       map_first;
  logic [DQ_W-1:0]       map_remap;
  logic [DQ_W-1:0]       train_map;
  logic [DQ_W-1:0]       dq_next;
  logic [NBYTES-1:0]     lvl_done;
  logic [NBYTES-1:0]     lvl_smp;
  logic                  dq_oe_next;

  // lane pairs skip ca4 and ca9, which wait for the remapped session
  for (genvar i = 0; i < 8; i++) begin : g_first
    localparam int CA_IDX = (i < 4) ? i : i + 1;
    assign map_first[2*i]   = ca_rise_reg[CA_IDX];
    assign map_first[2*i+1] = ca_s[CA_IDX];
  end

  assign map_remap = {6'h00, ca_s[9], ca_rise_reg[9],
                      6'h00, ca_s[4], ca_rise_reg[4]};
  assign train_map = (state_reg == TR_FIRST) ? map_first : map_remap;

  for (genvar b = 0; b < NBYTES; b++) begin : g_byte
    logic [7:0] cnt_reg;
    logic       busy_reg;
    logic       smp_reg;

    // feedback is a level held until the next strobe edge
    always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        cnt_reg  <= 8'h00;
        busy_reg <= 1'b0;
        smp_reg  <= 1'b0;
      end else if (!lvl_on) begin
        busy_reg <= 1'b0;
      end else if (dqs_rise[b]) begin
        smp_reg  <= ck_s;
        cnt_reg  <= 8'(LEVEL_OUT_CYC);
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        cnt_reg  <= cnt_reg - 8'h01;
        busy_reg <= (cnt_reg != 8'h01);
      end
    end

    assign lvl_done[b] = busy_reg & (cnt_reg == 8'h01);
    assign lvl_smp[b]  = smp_reg;
    assign dq_next[b*BYTE_W +: BYTE_W] =
      hit_exit         ? 8'h00 :
      sample_evt       ? train_map[b*BYTE_W +: BYTE_W] :
      (lvl_on && lvl_done[b]) ? {BYTE_W{lvl_smp[b]}} :
      dq_out[b*BYTE_W +: BYTE_W];
  end

  // dq floats at the falling edge that carries the exit write
  assign dq_oe_next = (state_next != TR_IDLE)
                      | (lvl_on & (dq_oe_out | (|lvl_done)));

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dq_out    <= '0;
      dq_oe_out <= 1'b0;
    end else begin
      dq_out    <= dq_next;
      dq_oe_out <= dq_oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // termination: pin is synchronised, so a few cycles of lag apply
  logic                  term_mode_en;
  logic                  term_pd_block;
  logic                  term_base;
  dctwo_term_type        term_next;

  assign term_mode_en  = |term_cfg_reg[1:0];
  assign term_pd_block = ~cke_s & ~term_cfg_reg[TERM_PDE_BIT];
  assign term_base     = term_mode_en & term_pin_s & ~read_busy_in
                         & ~term_pd_block & ~self_refresh_in
                         & ~deep_power_down_in & ~in_train;
  assign term_next.dq  = term_base & ~lvl_on;
  assign term_next.dqs = term_base;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      term_dq_out                <= 1'b0;
      term_dqs_out               <= 1'b0;
      termination_resistance_out <= 2'h0;
    end else begin
      term_dq_out                <= term_next.dq;
      term_dqs_out               <= term_next.dqs;
      termination_resistance_out <= term_cfg_reg[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_entry_state: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    hit_entry && state_reg == TR_IDLE |=> state_reg == TR_FIRST)
    else $error("training entry not taken");
  chk_exit_state: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    hit_exit && in_train |=> state_reg == TR_IDLE ##1 !dq_oe_out)
    else $error("training exit not taken or dq still driven");
  chk_remap_cke: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    state_reg == TR_FIRST && hit_remap && !cke_s
    |=> state_reg == TR_FIRST)
    else $error("remap accepted with clock enable low");
  chk_remap_taken: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    state_reg == TR_FIRST && hit_remap && cke_s
    |=> state_reg == TR_REMAP)
    else $error("remap not taken");
  chk_first_map: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    sample_evt && state_reg == TR_FIRST
    |=> dq_out[0] == $past(ca_rise_reg[0]) && dq_out[15] == $past(ca_s[8]))
    else $error("first session lane mapping wrong");
  chk_remap_map: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    sample_evt && state_reg == TR_REMAP
    |=> dq_out[9] == $past(ca_s[9]) && dq_out[1] == $past(ca_s[4])
        && dq_out[7:2] == 6'h00)
    else $error("remap lane mapping wrong");
  chk_train_term: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    in_train |=> !term_dq_out && !term_dqs_out)
    else $error("termination on during training");
  chk_term_zero: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    term_cfg_reg[1:0] == 2'h0 |=> !term_dq_out && !term_dqs_out)
    else $error("termination on with mode disabled");
  chk_pd_block: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !cke_s && !term_cfg_reg[TERM_PDE_BIT] |=> !term_dqs_out)
    else $error("termination on in power-down without enable");
  chk_level_dq: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    lvl_on && term_base |=> term_dqs_out && !term_dq_out)
    else $error("leveling termination split wrong");
  chk_level_fb: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    lvl_on && dqs_rise[0] && !g_byte[0].busy_reg
    |=> ##2 (dq_out[7:0] == {8{$past(ck_s, 3)}} || !lvl_on))
    else $error("leveling feedback not driven");

  cov_train_full: cover property (@(posedge mclk_in)
    state_reg == TR_REMAP ##[1:1000] state_reg == TR_IDLE);
  cov_level_fb: cover property (@(posedge mclk_in) lvl_on && |lvl_done);
  cov_term_on: cover property (@(posedge mclk_in) term_dq_out);
  cov_term_pd: cover property (@(posedge mclk_in) term_dqs_out && !cke_s);

endmodule : dctwo_top
`default_nettype wire

// ==== src/dctwo_pkg.sv ====
// constants, types and mode-register encodings for training and termination
package dctwo_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and clock
  localparam int          CLK_NS      = 50;
  localparam int          CA_W        = 10;
  localparam int          DQ_W        = 16;
  localparam int          BYTE_W      = 8;
  localparam int          NBYTES      = 2;
  localparam int          SYNC_W      = 16;

  ////////////////////////////////////////////////////////////////////////////
  // mode-register addresses and operands
  localparam logic [7:0]  TRAIN_ENTRY_ADDR = 8'h29;
  localparam logic [7:0]  TRAIN_ENTRY_OP   = 8'ha4;
  localparam logic [7:0]  TRAIN_EXIT_ADDR  = 8'h2a;
  localparam logic [7:0]  TRAIN_EXIT_OP    = 8'ha8;
  localparam logic [7:0]  TRAIN_REMAP_ADDR = 8'h30;
  localparam logic [7:0]  TRAIN_REMAP_OP   = 8'hc0;
  localparam logic [7:0]  LEVEL_CTRL_ADDR  = 8'h02;
  localparam logic [7:0]  TERM_CFG_ADDR    = 8'h0b;
  localparam logic [3:0]  MRW_OPCODE       = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int          LEVEL_EN_BIT     = 7;
  localparam int          TERM_PDE_BIT     = 2;
  localparam logic [7:0]  LEVEL_CTRL_RST   = 8'h00;
  localparam logic [7:0]  TERM_CFG_RST     = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing: leveling output delay is a longest time, so it rounds down
  localparam int          LEVEL_OUT_NS     = 100;
  localparam int          LEVEL_OUT_CYC    = (LEVEL_OUT_NS / CLK_NS < 1) ? 1 :
                                             LEVEL_OUT_NS / CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    TR_IDLE  = 3'b001,
    TR_FIRST = 3'b010,
    TR_REMAP = 3'b100
  } dctwo_train_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] op;
  } dctwo_mrw_type;

  typedef struct packed {
    logic dq;
    logic dqs;
  } dctwo_term_type;

endpackage : dctwo_pkg

// ==== src/dctwo_sync.sv ====
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module dctwo_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_in,
  input  wire logic         resetn_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : dctwo_sync
`default_nettype wire

// ==== tb/dctwo_ctrl_model.sv ====
// memory controller model: clock, commands, clock enable and strobes
`timescale 1ns/1ps
`default_nettype none
module dctwo_ctrl_model
  import dctwo_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic [DQ_W-1:0]   dq_in,
  output logic                   ck_t_out,
  output logic                   cs_n_out,
  output logic                   cke_out,
  output logic      [CA_W-1:0]   ca_out,
  output logic      [NBYTES-1:0] dqs_t_out
);
  initial begin
    ck_t_out  = 1'h0;
    cs_n_out  = 1'h1;
    cke_out   = 1'h1;
    ca_out    = 10'h000;
    dqs_t_out = 2'h0;
    #13;
    forever #200 ck_t_out = ~ck_t_out;
  end

  task automatic wait_mclk(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : wait_mclk

  task automatic set_cke(input logic v);
    @(posedge mclk_in);
    cke_out <= v;
  endtask : set_cke

  ////////////////////////////////////////////////////////////////////////////
  // halves change mid-phase so the synchronised bus is settled at each edge
  task automatic cmd(input logic [CA_W-1:0] r, input logic [CA_W-1:0] f);
    @(negedge ck_t_out);
    wait_mclk(2);
    ca_out   <= r;
    @(negedge ck_t_out);
    wait_mclk(2);
    cs_n_out <= 1'h0;
    @(posedge ck_t_out);
    wait_mclk(2);
    ca_out   <= f;
    @(negedge ck_t_out);
    wait_mclk(2);
    cs_n_out <= 1'h1;
    @(negedge ck_t_out);
    wait_mclk(2);
    ca_out   <= ~f;  // idle bus must not keep showing the last value
  endtask : cmd

  task automatic mode_reg_write_cmd(input logic [7:0] addr, input logic [7:0] op);
    cmd({addr[5:0], 4'h0}, {op, addr[7:6]});
  endtask : mode_reg_write_cmd

  ////////////////////////////////////////////////////////////////////////////
  // strobe rises d + 1 cycles after ck falls; later d moves it into ck high
  task automatic strobe(input int b, input int d);
    @(negedge ck_t_out);
    wait_mclk(d + 1);
    dqs_t_out[b] <= 1'h1;
    wait_mclk(4);
    dqs_t_out[b] <= 1'h0;
    wait_mclk(4);
  endtask : strobe

  task automatic sweep(input int b, output int d);
    for (d = 0; d < 8; d++) begin
      strobe(b, d);
      if (dq_in[b*BYTE_W] === 1'h1) break;
    end
  endtask : sweep
endmodule : dctwo_ctrl_model
`default_nettype wire

// ==== tb/dctwo_top_test.sv ====
// self-checking bench: training, leveling and termination scenarios
`timescale 1ns/1ps
`default_nettype none
module dctwo_top_test
  import dctwo_pkg::*;
;
  logic              mclk_in;
  logic              resetn_in;
  logic              term_pin;
  logic              read_busy;
  logic              self_refresh;
  logic              deep_pd;
  logic              ck_t;
  logic              cs_n;
  logic              cke;
  logic [CA_W-1:0]   ca;
  logic [NBYTES-1:0] dqs_t;
  logic [DQ_W-1:0]   dq;
  logic [1:0]        res;
  logic              dq_oe;
  logic              t_dq;
  logic              t_dqs;
  logic              train;
  logic              level;
  logic [DQ_W-1:0]   status;
  int                fails;
  int                compares;
  int                cycles;

  assign status = {9'h000, res, train, level, dq_oe, t_dq, t_dqs};

  dctwo_ctrl_model u_ctrl (
    .mclk_in   (mclk_in),
    .dq_in     (dq),
    .ck_t_out  (ck_t),
    .cs_n_out  (cs_n),
    .cke_out   (cke),
    .ca_out    (ca),
    .dqs_t_out (dqs_t)
  );

  dctwo_top u_dctwo_top (
    .mclk_in                    (mclk_in),
    .resetn_in                  (resetn_in),
    .ck_t_in                    (ck_t),
    .cs_n_in                    (cs_n),
    .cke_in                     (cke),
    .ca_in                      (ca),
    .dqs_t_in                   (dqs_t),
    .termination_pin_in         (term_pin),
    .read_busy_in               (read_busy),
    .self_refresh_in            (self_refresh),
    .deep_power_down_in         (deep_pd),
    .dq_out                     (dq),
    .dq_oe_out                  (dq_oe),
    .term_dq_out                (t_dq),
    .term_dqs_out               (t_dqs),
    .termination_resistance_out (res),
    .training_active_out        (train),
    .leveling_active_out        (level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic check(input logic [DQ_W-1:0] seen, input logic [DQ_W-1:0] e);
    compares++;
    if (seen !== e) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, e);
    end
  endtask : check

  task automatic summarize;
    if (fails == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // {pin, read, self refresh, deep power-down, cke}, then settle
  task automatic pins(input logic [4:0] v);
    @(posedge mclk_in);
    term_pin     <= v[4];
    read_busy    <= v[3];
    self_refresh <= v[2];
    deep_pd      <= v[1];
    u_ctrl.set_cke(v[0]);
    repeat (4) @(posedge mclk_in);
  endtask : pins

  function automatic logic [DQ_W-1:0] first_map(input logic [CA_W-1:0] r,
                                                input logic [CA_W-1:0] f);
    logic [DQ_W-1:0] d;
    int              k [8] = '{0, 1, 2, 3, 5, 6, 7, 8};
    for (int i = 0; i < 8; i++) begin
      d[2*i]   = r[k[i]];
      d[2*i+1] = f[k[i]];
    end
    return d;
  endfunction : first_map

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_termination;
    logic [5:0] tbl [7] = '{6'h23, 6'h02, 6'h32, 6'h23, 6'h2a, 6'h26, 6'h20};
    logic [1:0] r;
    pins(5'h11);
    for (int i = 0; i < 4; i++) begin
      r = i[1:0];
      u_ctrl.mode_reg_write_cmd(TERM_CFG_ADDR, {6'h00, r});
      check(status, {9'h000, r, 3'h0, {2{r != 2'h0}}});
    end
    for (int i = 0; i < 7; i++) begin
      pins(tbl[i][5:1]);
      check(status, tbl[i][0] ? 16'h0063 : 16'h0060);
    end
    pins(5'h11);
    u_ctrl.mode_reg_write_cmd(TERM_CFG_ADDR, 8'h07);
    pins(5'h10);
    check(status, 16'h0063);
    pins(5'h11);
  endtask : test_termination

  task automatic test_training;
    logic [CA_W-1:0] rs [3] = '{10'h3ff, 10'h155, 10'h0a5};
    logic [CA_W-1:0] fs [3] = '{10'h000, 10'h2aa, 10'h35a};
    u_ctrl.mode_reg_write_cmd(TRAIN_ENTRY_ADDR, TRAIN_ENTRY_OP);
    check(status, 16'h0074);
    for (int i = 0; i < 3; i++) begin
      u_ctrl.cmd(rs[i], fs[i]);
      check(dq, first_map(rs[i], fs[i]));
    end
    u_ctrl.set_cke(1'h0);
    u_ctrl.mode_reg_write_cmd(TRAIN_REMAP_ADDR, TRAIN_REMAP_OP);
    u_ctrl.set_cke(1'h1);
    u_ctrl.cmd(rs[1], fs[1]);
    check(dq, first_map(rs[1], fs[1]));
    u_ctrl.mode_reg_write_cmd(TRAIN_REMAP_ADDR, TRAIN_REMAP_OP);
    u_ctrl.cmd(10'h01f, 10'h200);
    check(dq, 16'h0201);
    u_ctrl.cmd(10'h20f, 10'h010);
    check(dq, 16'h0102);
    u_ctrl.mode_reg_write_cmd(TRAIN_EXIT_ADDR, TRAIN_EXIT_OP);
    check(status, 16'h0063);
    check(dq, 16'h0000);
  endtask : test_training

  // only the leveling exit write is issued while leveling runs
  task automatic test_leveling;
    int d;
    u_ctrl.mode_reg_write_cmd(LEVEL_CTRL_ADDR, 8'h80);
    u_ctrl.sweep(0, d);
    check(16'(d > 0 && d < 6), 16'h0001);
    check({8'h00, dq[7:0]}, 16'h00ff);
    u_ctrl.sweep(1, d);
    check(16'(d > 0 && d < 6), 16'h0001);
    check({8'h00, dq[15:8]}, 16'h00ff);
    check(status, 16'h006d);
    u_ctrl.mode_reg_write_cmd(LEVEL_CTRL_ADDR, 8'h00);
    check(status, 16'h0063);
  endtask : test_leveling

  ////////////////////////////////////////////////////////////////////////////
  always #25 mclk_in = ~mclk_in;

  // run needs about 800 cycles; the ceiling leaves ample margin
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    mclk_in      = 1'h0;
    resetn_in    = 1'h0;
    term_pin     = 1'h0;
    read_busy    = 1'h0;
    self_refresh = 1'h0;
    deep_pd      = 1'h0;
    repeat (8) @(posedge mclk_in);
    resetn_in <= 1'h1;
    repeat (4) @(posedge mclk_in);
    test_termination();
    test_training();
    test_leveling();
    summarize();
  end
endmodule : dctwo_top_test
`default_nettype wire
